/* File: pkg/pci_pkg.sv */
package pci_pkg;
  // Received control codes.
  localparam logic [6:0] PCI_NUL = 7'h00;
  localparam logic [6:0] PCI_ETX = 7'h03;
  localparam logic [6:0] PCI_EOT = 7'h04;
  localparam logic [6:0] PCI_ENQ = 7'h05;
  localparam logic [6:0] PCI_BEL = 7'h07;
  localparam logic [6:0] PCI_BS = 7'h08;
  localparam logic [6:0] PCI_HT = 7'h09;
  localparam logic [6:0] PCI_LF = 7'h0A;
  localparam logic [6:0] PCI_VT = 7'h0B;
  localparam logic [6:0] PCI_FF = 7'h0C;
  localparam logic [6:0] PCI_CR = 7'h0D;
  localparam logic [6:0] PCI_SO = 7'h0E;
  localparam logic [6:0] PCI_SI = 7'h0F;
  localparam logic [6:0] PCI_DLE = 7'h10;
  localparam logic [6:0] PCI_CAN = 7'h18;
  localparam logic [6:0] PCI_SUB = 7'h1A;
  localparam logic [6:0] PCI_ESC = 7'h1B;
  localparam logic [6:0] PCI_DEL = 7'h7F;
  localparam logic [6:0] PCI_SPACE = 7'h20;
  localparam logic [6:0] PCI_CSI_INTRO = 7'h5B;
  // Duplex modes.
  localparam logic [1:0] PCI_MODE_FULL = 2'h0;
  localparam logic [1:0] PCI_MODE_HALF_ETX = 2'h1;
  localparam logic [1:0] PCI_MODE_HALF_EOT = 2'h2;
  // Register byte offsets.
  localparam logic [4:0] PCI_REG_CTRL = 5'h00;
  localparam logic [4:0] PCI_REG_HMARG = 5'h04;
  localparam logic [4:0] PCI_REG_VMARG = 5'h08;
  localparam logic [4:0] PCI_REG_POS = 5'h0C;
  localparam logic [4:0] PCI_REG_HTAB = 5'h10;
  localparam logic [4:0] PCI_REG_VTAB = 5'h14;
  // Geometry and reset values.
  localparam logic [7:0] PCI_MAX_COL = 8'hD9;
  localparam logic [7:0] PCI_MAX_LINE = 8'hA8;
  localparam logic [7:0] PCI_RST_LM = 8'h01;
  localparam logic [7:0] PCI_RST_RM = 8'h84;
  localparam logic [7:0] PCI_RST_TM = 8'h01;
  localparam logic [7:0] PCI_RST_BM = 8'h42;
  localparam logic [3:0] PCI_BELL_MAX = 4'h8;
  // Tone timing.
  localparam int PCI_CLK_HZ = 200_000_000;
  localparam int PCI_BELL_HZ = 2400;
  localparam int PCI_BELL_MS = 100;
  localparam int PCI_TONE_HALF_CYC = PCI_CLK_HZ / (2 * PCI_BELL_HZ);
  localparam int PCI_TONE_LEN_CYC = (PCI_CLK_HZ / 1000) * PCI_BELL_MS;

  typedef struct packed {
    logic [2:0] national;
    logic sec_installed;
    logic alt_set_en;
    logic auto_nl;
    logic cr_newline;
    logic lnm;
    logic auto_disc_en;
    logic [1:0] mode;
  } pci_ctrl_t;

  typedef struct packed {
    logic err_glyph;
    logic apl;
    logic [2:0] national;
    logic [6:0] code;
    logic [7:0] col;
    logic [7:0] line;
  } pci_print_t;

  typedef enum logic [2:0] {
    PCI_ST_IDLE = 3'b001,
    PCI_ST_ESC = 3'b010,
    PCI_ST_CSI = 3'b100
  } pci_state_t;
endpackage

/* File: rtl/pci_interp.sv */
// The placing of the registers and the Avalon-MM slave port were decided locally.
`timescale 1ns/100ps
// How it works
// - NUL and DEL are dropped with no action and no output.
// - ETX turns the line round only in half duplex ETX mode.
// - EOT turns round in half EOT mode, else disconnects if enabled.
// - ENQ pulses the answerback transmit request.
// - Each counted bell sounds a short 2400 Hz square tone.
// - Pending bells are counted and never exceed eight.
// - BS steps the column back one unless at the left margin.
// - HT goes to next stop up to right margin, else margin plus one.
// - LF steps the line, or wraps to top margin at the bottom margin.
// - In newline mode LF, VT and FF also return to the left margin.
// - VT goes to next vertical stop up to bottom margin, else top.
// - FF moves to the top margin of the next page.
// - CR sets the column to the left margin.
// - With CR as new-line character, CR also steps the line.
// - SI selects the primary set when a secondary set is fitted.
// - SO selects APL only when fitted and alternate set enabled.
// - In half EOT mode a DLE before EOT makes it a disconnect.
// - CAN aborts and discards a partial escape sequence.
// - Parity errors and buffer overflow become SUB characters.
// - SUB prints the error glyph and cancels an escape sequence.
// - ESC starts collecting an escape sequence instead of printing.
// - Leaving APL restores the national set chosen before.
// - The column is never left of the left margin.
// - Going past margin plus one auto-newlines or rings and discards.
// - A line outside the vertical margins is forced to the top margin.
// - Unlisted control codes are ignored.
module pci_interp #(
  parameter int TONE_HALF_CYC = pci_pkg::PCI_TONE_HALF_CYC,
  parameter int TONE_LEN_CYC = pci_pkg::PCI_TONE_LEN_CYC
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rx_valid,
  input wire logic [6:0] rx_data,
  input wire logic rx_parity_err,
  input wire logic rx_overflow,
  output logic rx_ready,
  input wire logic tx_dle,
  output logic print_valid,
  output pci_pkg::pci_print_t print_out,
  output logic esc_valid,
  output logic [6:0] esc_char,
  output logic esc_abort,
  output logic turnaround,
  output logic disconnect,
  output logic answerback_req,
  output logic tone
);
  initial begin
    if (TONE_HALF_CYC < 1 || TONE_LEN_CYC < 2 * TONE_HALF_CYC) begin
      $error("pci_interp: tone timing parameters out of range");
    end
  end

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Lowest set stop above 'from' and not above 'limit'; bit 8 flags a find.
  function automatic logic [8:0] next_stop(input logic [255:0] map, input logic [7:0] from,
                                           input logic [7:0] limit);
    logic [8:0] r;
    r = 9'h000;
    for (int i = 255; i > 0; i--) begin
      if (map[i] && 8'(i) > from && 8'(i) <= limit) begin
        r = {1'b1, 8'(i)};
      end
    end
    return r;
  endfunction

  pci_pkg::pci_ctrl_t ctrl_q;
  logic [7:0] lm_q, rm_q, tm_q, bm_q;
  logic [7:0] col_q, col_d, line_q, line_d;
  logic [255:0] htab_q, vtab_q;
  logic apl_q, dle_q, ov_pend_q, ack_q;
  logic [3:0] bell_q;
  logic [24:0] tone_len_q;
  logic [16:0] tone_half_q;
  pci_pkg::pci_state_t state_q, state_d;
  logic proc, idle, is_print, ring, esc_take, abort_d;
  logic [6:0] code;
  logic [7:0] lf_line;
  logic [8:0] hfind, vfind;
  logic bus_wr, bus_rd;
  logic [31:0] wd_h, wd_v;

  // An overflow holds off the next character so its SUB lands where the loss was.
  assign rx_ready = !ov_pend_q;
  assign proc = (rx_valid && rx_ready) || ov_pend_q;
  assign code = (ov_pend_q || rx_parity_err) ? pci_pkg::PCI_SUB : rx_data;
  assign idle = (state_q == pci_pkg::PCI_ST_IDLE);
  assign is_print = code >= pci_pkg::PCI_SPACE && code != pci_pkg::PCI_DEL;
  assign lf_line = (line_q == bm_q) ? tm_q : line_q + 8'h01;
  assign hfind = next_stop(htab_q, col_q, rm_q);
  assign vfind = next_stop(vtab_q, line_q, bm_q);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ov_pend_q <= 1'b0;
    end else if (rx_overflow) begin
      ov_pend_q <= 1'b1;
    end else if (ov_pend_q) begin
      ov_pend_q <= 1'b0;
    end
  end

  // Position update for one received code.
  always_comb begin
    col_d = col_q;
    line_d = line_q;
    ring = 1'b0;
    if (proc && !(is_print && !idle && code != pci_pkg::PCI_SUB)) begin
      unique case (code)
        pci_pkg::PCI_BS: begin
          if (col_q > lm_q) begin
            col_d = col_q - 8'h01;
          end
        end
        pci_pkg::PCI_HT: col_d = hfind[8] ? hfind[7:0] : rm_q + 8'h01;
        pci_pkg::PCI_LF: begin
          line_d = lf_line;
          if (ctrl_q.lnm) begin
            col_d = lm_q;
          end
        end
        pci_pkg::PCI_VT: begin
          line_d = vfind[8] ? vfind[7:0] : tm_q;
          if (ctrl_q.lnm) begin
            col_d = lm_q;
          end
        end
        pci_pkg::PCI_FF: begin
          line_d = tm_q;
          if (ctrl_q.lnm) begin
            col_d = lm_q;
          end
        end
        pci_pkg::PCI_CR: begin
          col_d = lm_q;
          if (ctrl_q.cr_newline) begin
            line_d = lf_line;
          end
        end
        default: begin
          if (is_print || code == pci_pkg::PCI_SUB) begin
            if (col_q <= rm_q) begin
              col_d = col_q + 8'h01;
            end else if (ctrl_q.auto_nl) begin
              col_d = lm_q + 8'h01;
              line_d = lf_line;
            end else begin
              ring = 1'b1;
            end
          end
        end
      endcase
    end
    if (col_d < lm_q) begin
      col_d = lm_q;
    end
    if (line_d < tm_q || line_d > bm_q) begin
      line_d = tm_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      col_q <= pci_pkg::PCI_RST_LM;
      line_q <= pci_pkg::PCI_RST_TM;
    end else begin
      col_q <= col_d;
      line_q <= line_d;
    end
  end

  // Print path; NUL, DEL and unlisted controls never reach it.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      print_valid <= 1'b0;
      print_out <= '0;
    end else begin
      print_valid <= 1'b0;
      if (proc && !ring && ((is_print && idle) || code == pci_pkg::PCI_SUB)) begin
        print_valid <= 1'b1;
        print_out.err_glyph <= (code == pci_pkg::PCI_SUB);
        print_out.apl <= apl_q;
        print_out.national <= ctrl_q.national;
        print_out.code <= code;
        print_out.col <= (col_q > rm_q) ? lm_q : col_q;
        print_out.line <= (col_q > rm_q) ? lf_line : line_q;
      end
    end
  end

  // Escape collection; the sequence itself is decoded downstream.
  always_comb begin
    state_d = state_q;
    esc_take = 1'b0;
    abort_d = 1'b0;
    if (proc) begin
      if (code == pci_pkg::PCI_CAN || code == pci_pkg::PCI_SUB) begin
        state_d = pci_pkg::PCI_ST_IDLE;
        abort_d = !idle;
      end else if (code == pci_pkg::PCI_ESC) begin
        state_d = pci_pkg::PCI_ST_ESC;
      end else if (is_print) begin
        unique case (state_q)
          pci_pkg::PCI_ST_IDLE: state_d = pci_pkg::PCI_ST_IDLE;
          pci_pkg::PCI_ST_ESC: begin
            esc_take = 1'b1;
            if (code == pci_pkg::PCI_CSI_INTRO) begin
              state_d = pci_pkg::PCI_ST_CSI;
            end else if (code >= 7'h30) begin
              state_d = pci_pkg::PCI_ST_IDLE;
            end
          end
          pci_pkg::PCI_ST_CSI: begin
            esc_take = 1'b1;
            if (code >= 7'h40) begin
              state_d = pci_pkg::PCI_ST_IDLE;
            end
          end
          default: state_d = pci_pkg::PCI_ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= pci_pkg::PCI_ST_IDLE;
      esc_valid <= 1'b0;
      esc_char <= 7'h00;
      esc_abort <= 1'b0;
    end else begin
      state_q <= state_d;
      esc_valid <= esc_take;
      esc_abort <= abort_d;
      if (esc_take) begin
        esc_char <= code;
      end
    end
  end

  // Line discipline events; DLE memory lives only until the next received code.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      turnaround <= 1'b0;
      disconnect <= 1'b0;
      answerback_req <= 1'b0;
      dle_q <= 1'b0;
    end else begin
      turnaround <= proc && ((code == pci_pkg::PCI_ETX && ctrl_q.mode == pci_pkg::PCI_MODE_HALF_ETX)
                   || (code == pci_pkg::PCI_EOT && ctrl_q.mode == pci_pkg::PCI_MODE_HALF_EOT
                   && !dle_q));
      disconnect <= proc && code == pci_pkg::PCI_EOT
                    && ((ctrl_q.mode == pci_pkg::PCI_MODE_HALF_EOT) ? dle_q
                    : ctrl_q.auto_disc_en);
      answerback_req <= proc && code == pci_pkg::PCI_ENQ;
      if (ctrl_q.mode == pci_pkg::PCI_MODE_HALF_EOT && (tx_dle
          || (proc && code == pci_pkg::PCI_DLE))) begin
        dle_q <= 1'b1;
      end else if (proc || ctrl_q.mode != pci_pkg::PCI_MODE_HALF_EOT) begin
        dle_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      apl_q <= 1'b0;
    end else if (proc && code == pci_pkg::PCI_SO && ctrl_q.sec_installed
                 && ctrl_q.alt_set_en) begin
      apl_q <= 1'b1;
    end else if (proc && code == pci_pkg::PCI_SI && ctrl_q.sec_installed) begin
      apl_q <= 1'b0;
    end
  end

  // Bell queue: a new request in the cycle a tone finishes leaves the count unchanged.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bell_q <= 4'h0;
      tone_len_q <= '0;
      tone_half_q <= '0;
      tone <= 1'b0;
    end else begin
      logic add, done;
      add = (proc && code == pci_pkg::PCI_BEL) || ring;
      done = (bell_q != 4'h0) && (tone_len_q == 25'(TONE_LEN_CYC - 1));
      if (add && !done && bell_q != pci_pkg::PCI_BELL_MAX) begin
        bell_q <= bell_q + 4'h1;
      end else if (done && !add) begin
        bell_q <= bell_q - 4'h1;
      end
      if (bell_q == 4'h0 || done) begin
        tone_len_q <= '0;
        tone_half_q <= '0;
        tone <= 1'b0;
      end else begin
        tone_len_q <= tone_len_q + 25'h0000001;
        if (tone_half_q == 17'(TONE_HALF_CYC - 1)) begin
          tone_half_q <= '0;
          tone <= !tone;
        end else begin
          tone_half_q <= tone_half_q + 17'h00001;
        end
      end
    end
  end

  // Avalon slave with one wait state on every access.
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign bus_wr = avs_write && ack_q;
  assign bus_rd = avs_read && ack_q;
  assign wd_h = be_merge({8'h00, rm_q, 8'h00, lm_q}, avs_writedata, avs_byteenable);
  assign wd_v = be_merge({8'h00, bm_q, 8'h00, tm_q}, avs_writedata, avs_byteenable);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ack_q <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
      if ((avs_read || avs_write) && !ack_q) begin
        unique case (avs_address)
          pci_pkg::PCI_REG_CTRL: avs_readdata <= {21'h000000, ctrl_q};
          pci_pkg::PCI_REG_HMARG: avs_readdata <= {8'h00, rm_q, 8'h00, lm_q};
          pci_pkg::PCI_REG_VMARG: avs_readdata <= {8'h00, bm_q, 8'h00, tm_q};
          pci_pkg::PCI_REG_POS: avs_readdata <= {2'h0, bell_q, !idle, apl_q, line_q, 8'h00,
                                                 col_q};
          default: avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Margin writes that break 1 <= low <= high <= max are dropped whole.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_q <= '0;
      lm_q <= pci_pkg::PCI_RST_LM;
      rm_q <= pci_pkg::PCI_RST_RM;
      tm_q <= pci_pkg::PCI_RST_TM;
      bm_q <= pci_pkg::PCI_RST_BM;
      htab_q <= '0;
      vtab_q <= '0;
    end else if (bus_wr) begin
      unique case (avs_address)
        pci_pkg::PCI_REG_CTRL: ctrl_q <= 11'(be_merge({21'h000000, ctrl_q}, avs_writedata,
                                                      avs_byteenable));
        pci_pkg::PCI_REG_HMARG: begin
          if (wd_h[7:0] != 8'h00 && wd_h[7:0] <= wd_h[23:16]
              && wd_h[23:16] <= pci_pkg::PCI_MAX_COL) begin
            lm_q <= wd_h[7:0];
            rm_q <= wd_h[23:16];
          end
        end
        pci_pkg::PCI_REG_VMARG: begin
          if (wd_v[7:0] != 8'h00 && wd_v[7:0] <= wd_v[23:16]
              && wd_v[23:16] <= pci_pkg::PCI_MAX_LINE) begin
            tm_q <= wd_v[7:0];
            bm_q <= wd_v[23:16];
          end
        end
        pci_pkg::PCI_REG_HTAB: begin
          if (avs_byteenable[1] && avs_writedata[9]) begin
            htab_q <= '0;
          end else if (avs_byteenable[0] && avs_writedata[7:0] <= pci_pkg::PCI_MAX_COL) begin
            htab_q[avs_writedata[7:0]] <= avs_writedata[8];
          end
        end
        pci_pkg::PCI_REG_VTAB: begin
          if (avs_byteenable[1] && avs_writedata[9]) begin
            vtab_q <= '0;
          end else if (avs_byteenable[0] && avs_writedata[7:0] <= pci_pkg::PCI_MAX_LINE) begin
            vtab_q[avs_writedata[7:0]] <= avs_writedata[8];
          end
        end
        default: ;
      endcase
    end
  end

  null_drop_a: assert property (@(posedge clk_sys) disable iff (reset)
    proc && (code == pci_pkg::PCI_NUL || code == pci_pkg::PCI_DEL) |=> !print_valid)
    else $error("fill code reached print path");
  etx_other_a: assert property (@(posedge clk_sys) disable iff (reset)
    proc && code == pci_pkg::PCI_ETX && ctrl_q.mode != pci_pkg::PCI_MODE_HALF_ETX
    |=> !turnaround && !disconnect) else $error("ETX acted outside its mode");
  eot_disc_a: assert property (@(posedge clk_sys) disable iff (reset)
    proc && code == pci_pkg::PCI_EOT && ctrl_q.mode == pci_pkg::PCI_MODE_FULL
    |=> disconnect == $past(ctrl_q.auto_disc_en)) else $error("EOT disconnect wrong");
  enq_answer_a: assert property (@(posedge clk_sys) disable iff (reset)
    proc && code == pci_pkg::PCI_ENQ |=> answerback_req) else $error("ENQ not answered");
  bell_cap_a: assert property (@(posedge clk_sys) disable iff (reset)
    bell_q <= pci_pkg::PCI_BELL_MAX) else $error("too many pending bells");
  bs_step_a: assert property (@(posedge clk_sys) disable iff (reset)
    proc && code == pci_pkg::PCI_BS && col_q > lm_q && !bus_wr
    |=> col_q == $past(col_q) - 8'h01) else $error("backspace step wrong");
  cr_return_a: assert property (@(posedge clk_sys) disable iff (reset)
    proc && code == pci_pkg::PCI_CR && !bus_wr |=> col_q == lm_q)
    else $error("CR missed left margin");
  so_gate_a: assert property (@(posedge clk_sys) disable iff (reset)
    proc && code == pci_pkg::PCI_SO && !ctrl_q.alt_set_en |=> $stable(apl_q))
    else $error("SO shifted while disabled");
  cancel_esc_a: assert property (@(posedge clk_sys) disable iff (reset)
    proc && code == pci_pkg::PCI_CAN && !idle |=> esc_abort && state_q == pci_pkg::PCI_ST_IDLE)
    else $error("CAN left sequence open");
  line_range_a: assert property (@(posedge clk_sys) disable iff (reset)
    !$past(bus_wr) |-> line_q >= tm_q && line_q <= bm_q) else $error("line outside margins");

  bell_run_c: cover property (@(posedge clk_sys) disable iff (reset) bell_q == 4'h8);
  tab_hit_c: cover property (@(posedge clk_sys) disable iff (reset)
    proc && code == pci_pkg::PCI_HT && hfind[8]);
  auto_nl_c: cover property (@(posedge clk_sys) disable iff (reset)
    proc && is_print && idle && col_q > rm_q && ctrl_q.auto_nl);
  esc_abort_c: cover property (@(posedge clk_sys) disable iff (reset) esc_abort);
endmodule

/* File: bench/pci_host_model.sv */
`timescale 1ns/100ps
// Host data source: offers one received code at a time on the serial receive path.
module pci_host_model (
  input wire logic clk_sys,
  input wire logic rx_ready,
  output logic rx_valid,
  output logic [6:0] rx_data,
  output logic rx_parity_err,
  output logic rx_overflow,
  output logic tx_dle
);
  logic ok;

  initial begin
    rx_valid = 1'b0;
    rx_data = 7'h55;
    rx_parity_err = 1'b0;
    rx_overflow = 1'b0;
    tx_dle = 1'b0;
  end

  // A released data line shows the inverse of its last code, so stale data never looks valid.
  task automatic send(input logic [6:0] code, input logic perr);
    rx_valid <= 1'b1;
    rx_data <= code;
    rx_parity_err <= perr;
    forever begin
      #1;
      ok = rx_ready;
      @(posedge clk_sys);
      if (ok === 1'b1) break;
    end
    rx_valid <= 1'b0;
    rx_data <= ~code;
    rx_parity_err <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  // Signals that received characters were lost; the receiver must put a SUB in their place.
  task automatic lose();
    rx_overflow <= 1'b1;
    @(posedge clk_sys);
    rx_overflow <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
endmodule

/* File: bench/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  logic clk_sys, reset, avs_read, avs_write, avs_waitrequest, rx_valid, rx_parity_err;
  logic rx_overflow, rx_ready, tx_dle, print_valid, esc_valid, esc_abort, turnaround;
  logic disconnect, answerback_req, tone, tone_d;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdata;
  logic [6:0] rx_data, esc_char;
  pci_pkg::pci_print_t print_out, last_pr;
  int error_cnt, n_tests, n_pr, n_ta, n_dc, n_ab, n_ea, n_tn;
  logic [15:0] mt [7] = '{16'h0300, 16'h1302, 16'h2300, 16'h4401, 16'h0400, 16'h6402,
                          16'h5401};

  pci_interp #(.TONE_HALF_CYC(2), .TONE_LEN_CYC(400)) pci_interp_i (
    .clk_sys(clk_sys), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_parity_err(rx_parity_err), .rx_overflow(rx_overflow),
    .rx_ready(rx_ready), .tx_dle(tx_dle), .print_valid(print_valid), .print_out(print_out),
    .esc_valid(esc_valid), .esc_char(esc_char), .esc_abort(esc_abort),
    .turnaround(turnaround), .disconnect(disconnect), .answerback_req(answerback_req),
    .tone(tone));

  pci_host_model pci_host_model_i (
    .clk_sys(clk_sys), .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_parity_err(rx_parity_err), .rx_overflow(rx_overflow), .tx_dle(tx_dle));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (print_valid === 1'b1) begin
      n_pr++;
      last_pr = print_out;
    end
    if (turnaround === 1'b1) n_ta++;
    if (disconnect === 1'b1) n_dc++;
    if (answerback_req === 1'b1) n_ab++;
    if (esc_abort === 1'b1) n_ea++;
    if (tone !== tone_d) n_tn++;
    tone_d <= tone;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One wait state is expected, but the wait ends only on waitrequest low.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    logic ok;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    forever begin
      #1;
      ok = (avs_waitrequest === 1'b0);
      rdata = avs_readdata;
      @(posedge clk_sys);
      if (ok) break;
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic pos(input logic [7:0] col, input logic [7:0] line);
    bus(1'b0, pci_pkg::PCI_REG_POS, 32'h0);
    chk(rdata & 32'h00FF00FF, {8'h00, line, 8'h00, col});
  endtask

  task automatic ctl(input logic [31:0] v);
    bus(1'b1, pci_pkg::PCI_REG_CTRL, v);
  endtask

  task automatic tx(input logic [6:0] c);
    pci_host_model_i.send(c, 1'b0);
  endtask

  task automatic pq(input logic [27:0] e);
    chk({4'h0, last_pr}, {4'h0, e});
  endtask

  task automatic ev(input int p, input int t, input int d, input int a, input int e);
    chk({8'(n_pr), 6'(n_ta), 6'(n_dc), 6'(n_ab), 6'(n_ea)}, {8'(p), 6'(t), 6'(d), 6'(a), 6'(e)});
    {n_pr, n_ta, n_dc, n_ab, n_ea} = '0;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    {avs_address, avs_read, avs_write, avs_writedata, tone_d} = '0;
    {error_cnt, n_tests, n_pr, n_ta, n_dc, n_ab, n_ea, n_tn} = '0;
    reset = 1'b1;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    bus(1'b0, pci_pkg::PCI_REG_HMARG, 32'h0);
    chk(rdata, 32'h00840001);
    pos(8'h01, 8'h01);
    bus(1'b0, 5'h18, 32'h0);
    chk(rdata, 32'h0);
    tx(7'h41);
    pq({5'h00, 7'h41, 8'h01, 8'h01});
    pos(8'h02, 8'h01);
    tx(pci_pkg::PCI_BS);
    pos(8'h01, 8'h01);
    tx(pci_pkg::PCI_BS);
    tx(7'h42);
    pq({5'h00, 7'h42, 8'h01, 8'h01});
    ev(2, 0, 0, 0, 0);
    tx(pci_pkg::PCI_NUL);
    tx(pci_pkg::PCI_DEL);
    tx(7'h01);
    ev(0, 0, 0, 0, 0);
    pos(8'h02, 8'h01);
    bus(1'b1, pci_pkg::PCI_REG_HTAB, 32'h109);
    tx(pci_pkg::PCI_HT);
    pos(8'h09, 8'h01);
    tx(pci_pkg::PCI_HT);
    pos(8'h85, 8'h01);
    tx(pci_pkg::PCI_CR);
    pos(8'h01, 8'h01);
    tx(pci_pkg::PCI_ESC);
    tx(pci_pkg::PCI_CAN);
    ev(0, 0, 0, 0, 1);
    tx(pci_pkg::PCI_ESC);
    pci_host_model_i.send(7'h51, 1'b1);
    ev(1, 0, 0, 0, 1);
    pq({2'b10, 3'h0, pci_pkg::PCI_SUB, 8'h01, 8'h01});
    pci_host_model_i.lose();
    ev(1, 0, 0, 0, 0);
    pq({2'b10, 3'h0, pci_pkg::PCI_SUB, 8'h02, 8'h01});
    tx(pci_pkg::PCI_CR);
    tx(pci_pkg::PCI_LF);
    pos(8'h01, 8'h02);
    bus(1'b1, pci_pkg::PCI_REG_VMARG, 32'h00020001);
    tx(pci_pkg::PCI_LF);
    pos(8'h01, 8'h01);
    tx(pci_pkg::PCI_LF);
    tx(pci_pkg::PCI_FF);
    pos(8'h01, 8'h01);
    bus(1'b1, pci_pkg::PCI_REG_VTAB, 32'h102);
    tx(pci_pkg::PCI_VT);
    pos(8'h01, 8'h02);
    tx(pci_pkg::PCI_VT);
    pos(8'h01, 8'h01);
    ctl(32'h08);
    tx(7'h41);
    tx(pci_pkg::PCI_LF);
    pos(8'h01, 8'h02);
    ctl(32'h10);
    bus(1'b1, pci_pkg::PCI_REG_VMARG, 32'h00420001);
    tx(pci_pkg::PCI_CR);
    pos(8'h01, 8'h03);
    ctl(32'h5C0);
    tx(pci_pkg::PCI_SO);
    tx(7'h41);
    pq({2'b01, 3'h5, 7'h41, 8'h01, 8'h03});
    tx(pci_pkg::PCI_SI);
    tx(7'h41);
    pq({2'b00, 3'h5, 7'h41, 8'h02, 8'h03});
    ctl(32'h580);
    tx(pci_pkg::PCI_SO);
    tx(7'h41);
    pq({2'b00, 3'h5, 7'h41, 8'h03, 8'h03});
    ev(4, 0, 0, 0, 0);
    tx(pci_pkg::PCI_ENQ);
    ev(0, 0, 0, 1, 0);
    for (int i = 0; i < 7; i++) begin
      ctl({28'h0, mt[i][15:12]});
      tx({3'h0, mt[i][11:8]});
      ev(0, int'(mt[i][1]), int'(mt[i][0]), 0, 0);
    end
    ctl(32'h2);
    tx(pci_pkg::PCI_DLE);
    tx(pci_pkg::PCI_EOT);
    ev(0, 0, 1, 0, 0);
    n_tn = 0;
    repeat (9) tx(pci_pkg::PCI_BEL);
    bus(1'b0, pci_pkg::PCI_REG_POS, 32'h0);
    chk({28'h0, rdata[29:26]}, 32'h8);
    chk(32'(n_tn > 4), 32'h1);
    tally_and_finish();
  end
endmodule
